// File: sqf_core.sv
/*
 Byte serial port core with double-buffered transmit and error flags.
 Assumes a cpu side on clock supplying one-cycle strobes, and a serial link
 whose clock is link_clk (the pin clock as slave, our own clock as master).
*/
`timescale 1ns/10ps
`default_nettype none

module sqf_core (
   // system
   input wire logic clock,
   input wire logic rst_b,
   input wire logic link_clk,
   // cpu side
   input wire sqf_pkg::sqf_ctrl_t ctrl_in,
   input wire logic ctrl_wr,
   input wire logic status_rd,
   input wire logic data_wr,
   input wire logic data_rd,
   input wire logic [7:0] data_in,
   output var logic [7:0] data_out,
   output var sqf_pkg::sqf_stat_t status_out,
   output var sqf_pkg::sqf_ctrl_t ctrl_out,
   output var sqf_pkg::sqf_irq_t irq_out,
   // pins
   input wire logic sel_b_in,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] sel_sync_r;
   logic [1:0] sck_sync_r;
   logic sel_b;
   logic sck_s;
   logic sck_prev_r;
   logic sel_prev_r;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sel_sync_r <= 2'h3;
         sck_sync_r <= 2'h0;
         sck_prev_r <= 1'b0;
         sel_prev_r <= 1'b1;
      end else begin
         sel_sync_r <= {sel_sync_r[0], sel_b_in};
         sck_sync_r <= {sck_sync_r[0], sck_in};
         sck_prev_r <= sck_sync_r[1];
         sel_prev_r <= sel_sync_r[1];
      end
   end

   assign sel_b = sel_sync_r[1];
   assign sck_s = sck_sync_r[1];

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   sqf_pkg::sqf_ctrl_t ctrl_r;
   logic fault_set;
   logic master_fault;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r <= '0;
      end else if (ctrl_wr) begin
         ctrl_r <= ctrl_in;
      end else if (master_fault) begin
         // R16 enable cleared; R18 master select kept
         ctrl_r.module_enable <= 1'b0;
      end
   end

   assign ctrl_out = ctrl_r;

   // ------------------------------------------------------------
   // link side shifter (slave runs on pin clock, master on link_clk too)
   // ------------------------------------------------------------
   // the link domain receives a load token and the byte; sampling and shifting
   // happen on the rising edge of link_clk; the polarity select is not applied here
   logic [7:0] shift_r;
   logic [3:0] lbit_r;
   logic load_tgl_r;
   logic load_seen_r;
   logic load_pend;
   logic [7:0] load_word_r;
   logic [7:0] cur_byte;
   logic link_in;
   logic lclr_b;
   logic shift_full_r;
   logic done_tgl_r;
   logic strobe7_tgl_r;
   logic [7:0] rx_byte_r;
   logic [7:0] tx_hold_r;
   logic lrun_r;

   // R21 a deselected slave or a disabled module drops its bit count at once,
   // since the link clock may stop before the next edge could clear it
   assign lclr_b = rst_b && ctrl_r.module_enable && (ctrl_r.master_select || !sel_b_in);
   // the load word is held stable until the byte has gone out, so the token
   // may be read directly; the host must load ahead of the first link edge
   assign load_pend = (load_tgl_r != load_seen_r) && !lrun_r;
   assign cur_byte = load_pend ? load_word_r : shift_r;
   assign link_in = ctrl_r.master_select ? miso_in : mosi_in;

   always_ff @(posedge link_clk or negedge lclr_b) begin
      if (!lclr_b) begin
         lbit_r <= 4'h0;
         lrun_r <= 1'b0;
      end else if (lbit_r == sqf_pkg::BIT_COUNT - 4'h1) begin
         lbit_r <= 4'h0;
         lrun_r <= 1'b0;
      end else begin
         lbit_r <= lbit_r + 4'h1;
         lrun_r <= 1'b1;
      end
   end

   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         load_seen_r <= 1'b0;
         shift_r <= sqf_pkg::DATA_RESET;
         done_tgl_r <= 1'b0;
         strobe7_tgl_r <= 1'b0;
         rx_byte_r <= sqf_pkg::DATA_RESET;
      end else if (lclr_b) begin
         // R6 a queued byte enters only on the first edge of a transfer
         if (load_pend) begin
            load_seen_r <= load_tgl_r;
         end
         // R4 with nothing loaded the shifter content goes out again
         shift_r <= {cur_byte[6:0], link_in};
         if (lbit_r == 4'h6) begin
            // R8 bit 1 capture strobe
            strobe7_tgl_r <= ~strobe7_tgl_r;
         end
         if (lbit_r == sqf_pkg::BIT_COUNT - 4'h1) begin
            rx_byte_r <= {cur_byte[6:0], link_in};
            done_tgl_r <= ~done_tgl_r;
         end
      end
   end

   // ------------------------------------------------------------
   // link events into the bus domain
   // ------------------------------------------------------------
   logic [2:0] done_sync_r;
   logic [2:0] s7_sync_r;
   logic byte_done;
   logic bit1_strobe;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         done_sync_r <= 3'h0;
         s7_sync_r <= 3'h0;
      end else begin
         done_sync_r <= {done_sync_r[1:0], done_tgl_r};
         s7_sync_r <= {s7_sync_r[1:0], strobe7_tgl_r};
      end
   end

   assign byte_done = done_sync_r[2] ^ done_sync_r[1];
   assign bit1_strobe = s7_sync_r[2] ^ s7_sync_r[1];

   // ------------------------------------------------------------
   // transfer tracking and transmit queue
   // ------------------------------------------------------------
   logic busy_r;
   logic queued_r;
   logic tx_empty_r;
   logic [1:0] txe_cnt_r;
   logic slave_active;
   logic start_load;

   // R17 slave transfer window per phase
   assign slave_active = !ctrl_r.master_select && !sel_b &&
      (!ctrl_r.clock_phase_select || busy_r);
   // R1 R5 load when idle and a byte is queued; a second byte waits in the
   // buffer until the loaded one has gone out, so two bytes can be queued
   assign start_load = queued_r && !busy_r && !shift_full_r && !slave_active && ctrl_r.module_enable;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         busy_r <= 1'b0;
         queued_r <= 1'b0;
         shift_full_r <= 1'b0;
         tx_hold_r <= sqf_pkg::DATA_RESET;
         load_word_r <= sqf_pkg::DATA_RESET;
         load_tgl_r <= 1'b0;
      end else begin
         if (!ctrl_r.module_enable || master_fault) begin
            // R16 state counter cleared
            busy_r <= 1'b0;
            queued_r <= 1'b0;
            shift_full_r <= 1'b0;
         end else begin
            if (data_wr && tx_empty_r) begin
               tx_hold_r <= data_in;
               queued_r <= 1'b1;
            end else if (start_load) begin
               queued_r <= 1'b0;
               load_word_r <= tx_hold_r;
               load_tgl_r <= ~load_tgl_r;
            end
            if (start_load) begin
               shift_full_r <= 1'b1;
            end else if (byte_done) begin
               shift_full_r <= 1'b0;
            end
            if (start_load && ctrl_r.master_select) begin
               busy_r <= 1'b1;
            end else if (byte_done) begin
               busy_r <= 1'b0;
            end else if (!ctrl_r.master_select && ctrl_r.clock_phase_select
                  && !sel_b && sck_s != sck_prev_r) begin
               busy_r <= 1'b1;
            end
         end
      end
   end

   // R2 R5 tx empty set shortly after the load
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tx_empty_r <= 1'b1;
         txe_cnt_r <= 2'h0;
      end else if (!ctrl_r.module_enable || master_fault) begin
         tx_empty_r <= 1'b1;
         txe_cnt_r <= 2'h0;
      end else if (start_load) begin
         txe_cnt_r <= 2'(sqf_pkg::TXE_SET_CYCLES);
      end else if (txe_cnt_r != 2'h0) begin
         txe_cnt_r <= txe_cnt_r - 2'h1;
         if (txe_cnt_r == 2'h1) begin
            tx_empty_r <= 1'b1;
         end
      end else if (data_wr) begin
         tx_empty_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // master clock generation
   // ------------------------------------------------------------
   logic [3:0] div_r;
   logic sck_gen_r;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         div_r <= 4'h0;
         sck_gen_r <= 1'b0;
      end else if (busy_r && ctrl_r.master_select) begin
         if (div_r == sqf_pkg::HALF_BIT_CYCLES - 4'h1) begin
            div_r <= 4'h0;
            sck_gen_r <= ~sck_gen_r;
         end else begin
            div_r <= div_r + 4'h1;
         end
      end else begin
         div_r <= 4'h0;
         sck_gen_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // receive path and two-step clears
   // ------------------------------------------------------------
   logic rx_full_r;
   logic overrun_r;
   logic mode_fault_r;
   logic rx_armed_r;
   logic fault_armed_r;

   // R7 R9 byte enters only without pending overrun
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         data_out <= sqf_pkg::DATA_RESET;
      end else if (byte_done && !rx_full_r && !overrun_r) begin
         data_out <= rx_byte_r;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rx_armed_r <= 1'b0;
      end else if (status_rd) begin
         rx_armed_r <= rx_full_r || overrun_r;
      end else if (data_rd) begin
         rx_armed_r <= 1'b0;
      end
   end

   // R7 set wins over the clear
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rx_full_r <= 1'b0;
      end else if (byte_done && !rx_full_r && !overrun_r) begin
         rx_full_r <= 1'b1;
      end else if (data_rd && rx_armed_r) begin
         rx_full_r <= 1'b0;
      end
   end

   // R8 R10 overrun flag
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         overrun_r <= 1'b0;
      end else if (bit1_strobe && rx_full_r) begin
         overrun_r <= 1'b1;
      end else if (data_rd && rx_armed_r) begin
         overrun_r <= 1'b0;
      end
   end

   // R14 R15 R19 fault conditions, gated by detection enable
   logic fault_cond;
   assign fault_cond = ctrl_r.module_enable && (ctrl_r.master_select ? !sel_b :
      (sel_b && !sel_prev_r && (!ctrl_r.clock_phase_select || busy_r)));
   assign fault_set = fault_cond && ctrl_r.mode_fault_detect_enable;
   // R20 only a master fault touches enable and state
   assign master_fault = fault_set && ctrl_r.master_select;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         fault_armed_r <= 1'b0;
      end else if (fault_set) begin
         fault_armed_r <= 1'b0;
      end else if (status_rd) begin
         fault_armed_r <= mode_fault_r;
      end
   end

   // R22 clear needs armed read then control write, no fault present
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         mode_fault_r <= 1'b0;
      end else if (fault_set) begin
         mode_fault_r <= 1'b1;
      end else if (ctrl_wr && fault_armed_r) begin
         mode_fault_r <= 1'b0;
      end
   end

   assign status_out = '{tx_empty_flag: tx_empty_r, rx_full_flag: rx_full_r,
      overrun_flag: overrun_r, mode_fault_flag: mode_fault_r};

   // ------------------------------------------------------------
   // requests and pins
   // ------------------------------------------------------------
   always_comb begin
      // R23 tx request needs enable
      irq_out.tx_irq = ctrl_r.tx_irq_enable && ctrl_r.module_enable && tx_empty_r;
      irq_out.rx_irq = ctrl_r.rx_irq_enable && rx_full_r;
      // R11 shared error request
      irq_out.err_irq = ctrl_r.error_irq_enable && (overrun_r || mode_fault_r);
   end

   // R13 R16 R21 pin directions; disabled module releases pins
   assign sck_oe = ctrl_r.module_enable && ctrl_r.master_select;
   assign mosi_oe = ctrl_r.module_enable && ctrl_r.master_select;
   assign miso_oe = ctrl_r.module_enable && !ctrl_r.master_select && !sel_b;
   assign sck_out = sck_gen_r ^ ctrl_r.clock_polarity_select;
   assign mosi_out = cur_byte[7];
   assign miso_out = cur_byte[7];

endmodule : sqf_core

`default_nettype wire

// File: sqf_core_bench.sv
/*
 Self-checking bench for sqf_core: cpu strobe tasks, far master, checker.
 Assumes the package, checker and far master are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none

module sqf_core_bench;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] stb = 4'h0;
   logic [7:0] din = 8'h00;
   logic [7:0] cv = 8'h00;
   int mismatches = 0;
   int n_checks = 0;
   wire logic lclk, far_sel_b, far_mosi, sck_w, mosi_w, miso_w;
   logic [7:0] dout;
   sqf_pkg::sqf_stat_t st;
   sqf_pkg::sqf_ctrl_t co;
   logic sck_o, sck_e, mosi_o, mosi_e, miso_o, miso_e;
   always #10 clock = ~clock;
   // a master reads back its own mosi through the loop
   assign sck_w = sck_e ? sck_o : lclk;
   assign mosi_w = mosi_e ? mosi_o : far_mosi;
   assign miso_w = miso_e ? miso_o : mosi_w;
   sqf_core i_dut (.clock(clock), .rst_b(rst_b), .link_clk(lclk), .ctrl_in(sqf_pkg::sqf_ctrl_t'(cv)),
      .ctrl_wr(stb[0]), .status_rd(stb[1]), .data_wr(stb[2]), .data_rd(stb[3]), .data_in(din),
      .data_out(dout), .status_out(st), .ctrl_out(co), .irq_out(), .sel_b_in(far_sel_b), .sck_in(sck_w),
      .sck_out(sck_o), .sck_oe(sck_e), .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe(mosi_e),
      .miso_in(miso_w), .miso_out(miso_o), .miso_oe(miso_e));
   sqf_far_master i_far (.lclk(lclk), .sel_b(far_sel_b), .mosi(far_mosi), .miso(miso_w));
   // ----------
   // tasks
   // ----------
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test
   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // s: bit0 ctrl write, bit1 status read, bit2 data write, bit3 data read
   task acc(input logic [3:0] s, input logic [7:0] v);
      @(posedge clock);
      stb <= s;
      din <= v;
      if (s[0]) begin
         cv <= v;
      end
      @(posedge clock);
      stb <= 4'h0;
      @(negedge clock);
   endtask : acc
   task wait_st(input int b, input logic v);
      int i;
      for (i = 0; i < 200 && st[b] !== v; i++) @(negedge clock);
      if (i == 200) begin
         mismatches++;
         stop_test();
      end
   endtask : wait_st
   task stat(input logic [7:0] exp);
      chk("status", {4'h0, st}, exp);
   endtask : stat
   // ----------
   // sequence
   // ----------
   initial begin
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      repeat (3) @(negedge clock);
      stat(8'h08);
      chk("pins", {5'h00, sck_e, mosi_e, miso_e}, 8'h00);
      acc(4'h1, 8'hAF);
      acc(4'h4, 8'hA5);
      stat(8'h00);
      repeat (2) @(negedge clock);
      stat(8'h08);
      acc(4'h4, 8'h3C);
      repeat (4) @(negedge clock);
      stat(8'h00);
      i_far.xfer(8'h5A, 8);
      wait_st(2, 1'b1);
      chk("rx", dout, 8'h5A);
      chk("far", i_far.rx_r, 8'hA5);
      stat(8'h0C);
      acc(4'h2, 8'h00);
      acc(4'h8, 8'h00);
      stat(8'h08);
      i_far.xfer(8'h81, 8);
      wait_st(2, 1'b1);
      chk("far", i_far.rx_r, 8'h3C);
      acc(4'h2, 8'h00);
      acc(4'h8, 8'h00);
      acc(4'h2, 8'h00);
      i_far.xfer(8'h7E, 8);
      wait_st(2, 1'b1);
      chk("far", i_far.rx_r, 8'h81);
      i_far.xfer(8'h11, 8);
      wait_st(1, 1'b1);
      chk("rx", dout, 8'h7E);
      stat(8'h0E);
      acc(4'h2, 8'h00);
      acc(4'h8, 8'h00);
      stat(8'h08);
      i_far.xfer(8'h00, 0);
      stat(8'h08);
      i_far.xfer(8'hFF, 3);
      wait_st(0, 1'b1);
      chk("ctrl", co, 8'hAF);
      acc(4'h2, 8'h00);
      acc(4'h1, 8'h0F);
      stat(8'h08);
      acc(4'h1, 8'h8F);
      i_far.xfer(8'h00, 0);
      stat(8'h09);
      acc(4'h1, 8'h87);
      stat(8'h09);
      acc(4'h2, 8'h00);
      acc(4'h1, 8'h87);
      i_far.xfer(8'h00, 0);
      stat(8'h08);
      acc(4'h1, 8'h4F);
      acc(4'h1, 8'hCF);
      repeat (3) @(negedge clock);
      chk("pins", {5'h00, sck_e, mosi_e, miso_e}, 8'h06);
      acc(4'h4, 8'hC3);
      wait_st(3, 1'b1);
      acc(4'h4, 8'h96);
      stat(8'h00);
      i_far.run(150);
      wait_st(3, 1'b1);
      chk("rx", dout, 8'hC3);
      stat(8'h0E);
      acc(4'h2, 8'h00);
      acc(4'h8, 8'h00);
      i_far.sel(1'b0);
      stat(8'h09);
      chk("ctrl", co, 8'h4F);
      chk("pins", {5'h00, sck_e, mosi_e, miso_e}, 8'h00);
      i_far.sel(1'b1);
      stop_test();
   end
endmodule : sqf_core_bench

`default_nettype wire

// File: sqf_core_props.sv
/*
 Concurrent checks on the ports of sqf_core.
 Assumes one bus clock domain and the bind at the foot of this file.
*/
`timescale 1ns/10ps
`default_nettype none

module sqf_core_props (
   // system
   input wire logic clock,
   input wire logic rst_b,
   // cpu side
   input wire logic ctrl_wr,
   input wire logic data_wr,
   input wire logic data_rd,
   input wire logic [7:0] data_out,
   input wire sqf_pkg::sqf_stat_t status_out,
   input wire sqf_pkg::sqf_ctrl_t ctrl_out,
   input wire sqf_pkg::sqf_irq_t irq_out,
   // pins
   input wire logic sel_b_in,
   input wire logic sck_oe,
   input wire logic mosi_oe,
   input wire logic miso_oe
);
   logic txe, rxf, ovr, mdf, en, ms;
   assign {txe, rxf, ovr, mdf} = status_out;
   assign en = ctrl_out.module_enable;
   assign ms = ctrl_out.master_select;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // ----------
   // flags
   // ----------
   chk_txe_fall: assert property ($fell(txe) |-> $past(data_wr))
      else $error("tx empty fell with no data write");
   chk_txe_clear: assert property (data_wr && txe && en |=> !txe)
      else $error("data write left tx empty set");
   chk_ovr_hold: assert property (ovr && $past(ovr) |-> $stable(data_out))
      else $error("rx data changed while overrun pends");
   chk_ovr_clear: assert property ($fell(ovr) |-> $past(data_rd))
      else $error("overrun cleared without data read");
   chk_fault_clear: assert property ($fell(mdf) |-> $past(ctrl_wr))
      else $error("mode fault cleared without control write");
   chk_fault_block: assert property (!ctrl_out.mode_fault_detect_enable [*2] |-> !$rose(mdf))
      else $error("mode fault set while detection is off");
   chk_master_fault: assert property ($rose(mdf) && ms |-> ##[0:1] (!en && txe && ms))
      else $error("master fault side effects missing");
   // ----------
   // pins and requests
   // ----------
   chk_pin_dir: assert property ((en && ms) [*3] |-> sck_oe && mosi_oe && !miso_oe)
      else $error("master pin directions wrong");
   chk_miso_float: assert property (sel_b_in [*3] |-> !miso_oe)
      else $error("miso driven while deselected");
   chk_err_irq: assert property (irq_out.err_irq == (ctrl_out.error_irq_enable && (ovr || mdf)))
      else $error("error request mismatch");
   chk_irq_gate: assert property (irq_out.tx_irq == (ctrl_out.tx_irq_enable && en && txe)
      && irq_out.rx_irq == (ctrl_out.rx_irq_enable && rxf))
      else $error("tx or rx request mismatch");
   cover property ($rose(ovr));
   cover property ($rose(mdf) && ms);
   cover property ($rose(rxf));
endmodule : sqf_core_props

bind sqf_core sqf_core_props i_props (.clock(clock), .rst_b(rst_b), .ctrl_wr(ctrl_wr), .data_wr(data_wr),
   .data_rd(data_rd), .data_out(data_out), .status_out(status_out), .ctrl_out(ctrl_out), .irq_out(irq_out),
   .sel_b_in(sel_b_in), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe));

`default_nettype wire

// File: sqf_far_master.sv
/*
 Far-end serial master: frames bytes to the block as slave, and runs the
 link clock while the block is master. Assumes idle-low clock polarity.
*/
`timescale 1ns/10ps
`default_nettype none

module sqf_far_master (
   // link pins
   output logic lclk,
   output logic sel_b,
   output logic mosi,
   input wire logic miso
);
   logic [7:0] rx_r;
   initial begin
      lclk = 1'b0;
      sel_b = 1'b1;
      mosi = 1'b0;
      rx_r = 8'h00;
   end
   task xfer(input logic [7:0] tx, input int n);
      sel_b = 1'b0;
      #47;
      // data set up half a period ahead of the rising edge, miso taken just before it
      for (int i = 7; i > 7 - n; i--) begin
         mosi = tx[i];
         #7.5;
         rx_r = {rx_r[6:0], miso};
         lclk = 1'b1;
         #7.5;
         lclk = 1'b0;
      end
      #47;
      sel_b = 1'b1;
      // released line: no stale bit left on it
      mosi = ~mosi;
      #83;
   endtask : xfer
   task run(input int n);
      repeat (n) begin
         lclk = 1'b1;
         #7.5;
         lclk = 1'b0;
         #7.5;
      end
   endtask : run
   task sel(input logic v);
      sel_b = v;
      #200;
   endtask : sel
endmodule : sqf_far_master

`default_nettype wire

// File: sqf_pkg.sv
/*
 Package for the serial queue and error-flag block: counts, reset values and
 the carrier structs used at its ports. Assumes nothing of its surroundings.
*/
//
// Contract
// R1: a master starts a queued byte right after the previous one, no software step.
// R2: tx empty is high when the buffer is free; data write clears, shifter load sets.
// R3: software writes data only while tx empty reads high.
// R4: with no new byte the shifter contents are sent again.
// R5: idle with empty buffer, tx empty sets again within two bus cycles.
// R6: an active slave loads its shifter only after the running transfer.
// R7: each received byte sets rx full; status read then data read clears it.
// R8: overrun sets if rx data is unread at the bit 1 capture strobe.
// R9: while overrun pends, new bytes do not enter rx data nor set rx full.
// R10: overrun clears on status read followed by data read.
// R11: error enable lets overrun or mode fault raise the shared error request.
// R12: without the error enable, software rereads status after the data read.
// R13: master select drives clock and mosi out; cleared it drives miso instead.
// R14: with detection on, fault when slave select rises mid-transfer or master select falls.
// R15: clearing detection enable keeps a set fault flag but blocks new setting.
// R16: master fault clears enable, sets tx empty, clears counter, releases pins.
// R17: slave transfer spans select fall (phase 0) or first edge (phase 1) to idle.
// R18: a fault never changes master select.
// R19: phase 0 select then deselect without clocks faults; phase 1 does not.
// R20: a slave fault leaves enable and logic untouched.
// R21: a deselected slave floats miso and ignores every serial clock edge.
// R22: fault clears on status read seen set then control write, with no fault present.
// R23: tx request needs module enable; rx request does not.
package sqf_pkg;

   // bus cycles from shifter load to tx empty set, at most two
   localparam int unsigned TXE_SET_CYCLES = 1;
   localparam logic [3:0] BIT_COUNT = 4'h8;
   // half bit period in bus cycles for the master clock divider
   localparam logic [3:0] HALF_BIT_CYCLES = 4'h2;
   localparam logic [7:0] DATA_RESET = 8'h00;

   typedef struct packed {
      logic module_enable;
      logic master_select;
      logic clock_phase_select;
      logic clock_polarity_select;
      logic mode_fault_detect_enable;
      logic error_irq_enable;
      logic tx_irq_enable;
      logic rx_irq_enable;
   } sqf_ctrl_t;

   typedef struct packed {
      logic tx_empty_flag;
      logic rx_full_flag;
      logic overrun_flag;
      logic mode_fault_flag;
   } sqf_stat_t;

   typedef struct packed {
      logic tx_irq;
      logic rx_irq;
      logic err_irq;
   } sqf_irq_t;

endpackage : sqf_pkg
